// ==== hw/io_cell_map.svh ====
/*
 Offsets, field positions and reset values of the pad cell register pair.
 Assumes APB with 32-bit data; every register takes one aligned word.
*/
`ifndef IO_CELL_MAP_SVH
`define IO_CELL_MAP_SVH

// ==========================================================
// register offsets
`define IO_CFG_OFFSET 12'h000
`define IO_STATUS_OFFSET 12'h004

// ==========================================================
// configuration fields
`define IO_CFG_IN_INIT 0
`define IO_CFG_OUT_INIT 1
`define IO_CFG_IN_INVERT 2
`define IO_CFG_OUT_INVERT 3
`define IO_CFG_CE_INPUT 4
`define IO_CFG_CE_OUTPUT 5
`define IO_CFG_PAD_LO 6
`define IO_CFG_PAD_HI 7
`define IO_CFG_WIDTH 8
`define IO_CFG_RESET 8'h00

// ==========================================================
// status fields
`define IO_ST_IN_Q 0
`define IO_ST_OUT_Q 1
`define IO_ST_PAD 2

`endif

// ==== hw/io_cell_pkg.sv ====
/*
 Types shared by the pad cell register pair.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package io_cell_pkg;
   // ==========================================================
   // unused pad default state
   typedef enum logic [1:0] {
      pad_pull_up_mode = 2'b00,
      pad_pull_down_mode = 2'b01,
      pad_driven_mode = 2'b10,
      pad_external_mode = 2'b11
   } pad_mode_t;
endpackage

// ==== hw/pad_cell.sv ====
/*
 Pad cell: one input and one output flip-flop between a package pad and the
 fabric, with per-flip-flop clock edge, a shared enable, global set/reset and
 the unused-pad pull state; configured and observed over APB.
 Assumes pad and both cell clocks are asynchronous to sys_clk and much slower
 (each high and low phase lasts at least three sys_clk periods); fabric
 signals are on sys_clk.
*/
// Our own choices: the register addresses and the APB interface to the registers.
// Overview of operation
// (RULE_01) global set/reset forces both flip-flops to init
// (RULE_02) each flip-flop has its own init value
// (RULE_03) no set/reset besides global set/reset
// (RULE_04) power-on state uses same init selection
// (RULE_05) separate input and output side clocks
// (RULE_06) each clock edge individually invertible
// (RULE_07) cell clocks independent of other cells
// (RULE_08) shared enable applied to input, output, both
// (RULE_09) shared enable active high, never inverted
// (RULE_10) unused pad defaults to pull-up
// (RULE_11) pad may pull down, drive, or float
// (RULE_12) disabled flip-flop holds; otherwise captures each edge

`include "io_cell_map.svh"

module pad_cell (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe,
   output logic pad_pull_up,
   output logic pad_pull_down,
   input wire logic input_side_clock,
   input wire logic output_side_clock,
   input wire logic shared_clock_enable,
   input wire logic global_set_reset,
   input wire logic fabric_out_data,
   output logic fabric_in_data
);
   // ==========================================================
   // helper functions
   // edge test on the filtered level; inv selects the falling edge
   function automatic logic edge_hit(
      input logic prev,
      input logic now,
      input logic inv
   );
      if (inv) begin
         edge_hit = prev & ~now;
      end else begin
         edge_hit = ~prev & now;
      end
   endfunction

   // one full-address compare; anything else answers with an error
   function automatic logic addr_is(
      input logic [11:0] a,
      input logic [11:0] off
   );
      addr_is = (a == off);
   endfunction

   // decode of the pad mode field, shared by every pad control
   function automatic logic mode_is(
      input io_cell_pkg::pad_mode_t m,
      input io_cell_pkg::pad_mode_t want
   );
      mode_is = (m == want);
   endfunction

   // status layout kept in one place so the read mux stays small
   function automatic logic [31:0] status_word(
      input logic in_q,
      input logic out_q,
      input logic pad
   );
      status_word = 32'h0;
      status_word[`IO_ST_IN_Q] = in_q;
      status_word[`IO_ST_OUT_Q] = out_q;
      status_word[`IO_ST_PAD] = pad;
   endfunction

   // ==========================================================
   // state shared between sections
   // init values of reset come from the reset configuration, so power-on
   // and a later global set/reset agree until the init bits are rewritten
   localparam logic [`IO_CFG_WIDTH-1:0] cfg_reset_value = `IO_CFG_RESET;

   logic [`IO_CFG_WIDTH-1:0] cfg_r;
   logic [`IO_CFG_WIDTH-1:0] cfg_nxt;
   logic in_q_r;
   logic in_q_nxt;
   logic out_q_r;
   logic out_q_nxt;
   logic pready_r;
   logic pready_nxt;
   io_cell_pkg::pad_mode_t pad_mode;

   // ==========================================================
   // pin synchronisers: index 0 pad, 1 input clock, 2 output clock
   logic [2:0] pin_raw;
   logic [2:0] s1_r;
   logic [2:0] s2_r;
   logic [2:0] s3_r;
   logic [2:0] lvl_r;
   logic [2:0] lvl_nxt;

   // each cell has its own clock pins, never shared with a neighbour
   assign pin_raw = {output_side_clock, input_side_clock, pad_in}; // see (RULE_05) (RULE_07)

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         // a change only counts once the second and third stage agree
         always_comb begin
            lvl_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : lvl_r[gi];
         end
      end
   endgenerate

   // filter costs a cycle of latency but rejects single-sample glitches
   // reset low: a cell clock idling low gives no false edge after reset
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s1_r <= 3'h0;
         s2_r <= 3'h0;
         s3_r <= 3'h0;
         lvl_r <= 3'h0;
      end else begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
         lvl_r <= lvl_nxt;
      end
   end

   // ==========================================================
   // configuration register
   logic wr_take;
   logic hit_cfg;
   logic hit_st;

   assign hit_cfg = addr_is(paddr, `IO_CFG_OFFSET);
   assign hit_st = addr_is(paddr, `IO_STATUS_OFFSET);
   // a write lands only on the access edge that carries pready
   assign wr_take = psel & penable & pready_r & pwrite;
   assign pad_mode = io_cell_pkg::pad_mode_t'(cfg_r[`IO_CFG_PAD_HI:`IO_CFG_PAD_LO]);

   // upper write bits are dropped; they read back as zero
   always_comb begin
      cfg_nxt = cfg_r;
      if (wr_take && hit_cfg) begin
         cfg_nxt = pwdata[`IO_CFG_WIDTH-1:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cfg_r <= cfg_reset_value; // see (RULE_10)
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // ==========================================================
   // bus answer
   logic [31:0] prdata_nxt;
   logic pslverr_nxt;
   logic setup_seen;
   logic addr_ok;

   assign setup_seen = psel & ~penable;
   // status is read-only, so a write to it is refused like an unmapped hole
   assign addr_ok = hit_cfg | (hit_st & ~pwrite);

   // pready stands one cycle; a held psel cannot retrigger it
   always_comb begin
      // answer arrives in the first access cycle, zero wait states
      pready_nxt = setup_seen;
      pslverr_nxt = setup_seen & ~addr_ok;
      prdata_nxt = 32'h0;
      if (setup_seen && !pwrite) begin
         if (hit_cfg) begin
            prdata_nxt[`IO_CFG_WIDTH-1:0] = cfg_r;
         end else if (hit_st) begin
            prdata_nxt = status_word(in_q_r, out_q_r, lvl_r[0]);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         prdata <= 32'h0;
         pready_r <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr <= pslverr_nxt;
      end
   end

   assign pready = pready_r;

   // ==========================================================
   // clock edge and enable selection
   logic in_edge;
   logic out_edge;
   logic in_en;
   logic out_en;

   // edge test uses the level about to be latched, so both share one cycle
   assign in_edge = edge_hit(lvl_r[1], lvl_nxt[1], cfg_r[`IO_CFG_IN_INVERT]); // see (RULE_06)
   assign out_edge = edge_hit(lvl_r[2], lvl_nxt[2], cfg_r[`IO_CFG_OUT_INVERT]); // see (RULE_06)
   // enable used straight, no inversion option
   assign in_en = shared_clock_enable | ~cfg_r[`IO_CFG_CE_INPUT]; // see (RULE_08) (RULE_09)
   assign out_en = shared_clock_enable | ~cfg_r[`IO_CFG_CE_OUTPUT]; // see (RULE_08) (RULE_09)

   // ==========================================================
   // input flip-flop
   always_comb begin
      in_q_nxt = in_q_r;
      // only global set/reset overrides capture; no per-cell reset exists
      if (global_set_reset) begin
         in_q_nxt = cfg_r[`IO_CFG_IN_INIT]; // see (RULE_01) (RULE_02) (RULE_03)
      end else if (in_edge && in_en) begin
         // filtered pad level, updated on the same edge as the clock level
         in_q_nxt = lvl_nxt[0]; // see (RULE_12)
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         in_q_r <= cfg_reset_value[`IO_CFG_IN_INIT]; // see (RULE_04)
      end else begin
         in_q_r <= in_q_nxt;
      end
   end

   // ==========================================================
   // output flip-flop
   always_comb begin
      out_q_nxt = out_q_r;
      // global set/reset wins over a capture in the same cycle
      if (global_set_reset) begin
         out_q_nxt = cfg_r[`IO_CFG_OUT_INIT]; // see (RULE_01) (RULE_02)
      end else if (out_edge && out_en) begin
         out_q_nxt = fabric_out_data; // see (RULE_12)
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         out_q_r <= cfg_reset_value[`IO_CFG_OUT_INIT]; // see (RULE_04)
      end else begin
         out_q_r <= out_q_nxt;
      end
   end

   // ==========================================================
   // pad drive and pulls
   logic pad_out_nxt;
   logic pad_oe_nxt;
   logic pad_pull_up_nxt;
   logic pad_pull_down_nxt;
   logic fabric_in_nxt;

   // data outputs follow the next flip-flop value so they match it cycle for cycle; drive and pulls lag cfg_r a cycle
   always_comb begin
      pad_out_nxt = out_q_nxt;
      fabric_in_nxt = in_q_nxt;
      pad_oe_nxt = mode_is(pad_mode, io_cell_pkg::pad_driven_mode); // see (RULE_11)
      pad_pull_up_nxt = mode_is(pad_mode, io_cell_pkg::pad_pull_up_mode); // see (RULE_10)
      pad_pull_down_nxt = mode_is(pad_mode, io_cell_pkg::pad_pull_down_mode); // see (RULE_11)
      // external mode leaves all three low and the pad to its outside driver
   end

   // pull-up on from reset so a fresh pad never floats
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pad_out <= 1'b0;
         pad_oe <= 1'b0;
         pad_pull_up <= 1'b1; // see (RULE_10)
         pad_pull_down <= 1'b0;
         fabric_in_data <= 1'b0;
      end else begin
         pad_out <= pad_out_nxt;
         pad_oe <= pad_oe_nxt;
         pad_pull_up <= pad_pull_up_nxt;
         pad_pull_down <= pad_pull_down_nxt;
         fabric_in_data <= fabric_in_nxt;
      end
   end
endmodule

// ==== bench/pad_model.sv ====
/* pad model: resolves the pad level from all drivers.
   assumes pad_cell outputs and a bench driver ext_en/ext_val */
module pad_model (
   input wire logic sys_clk, pad_out, pad_oe, pad_pull_up, pad_pull_down, ext_en, ext_val,
   output logic pad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // undriven pad has no trusted level, so keep it moving
   logic float_r = 1'b0;
   always @(posedge sys_clk) float_r <= ~float_r;
   assign pad_in = pad_oe ? pad_out : ext_en ? ext_val :
      pad_pull_up ? 1'b1 : pad_pull_down ? 1'b0 : float_r;
endmodule

// ==== bench/pad_cell_asserts.sv ====
/* concurrent checks on the pad cell ports.
   assumes binding into pad_cell; config shadowed from apb writes */
module pad_cell_asserts (
   input wire logic sys_clk, reset, psel, penable, pwrite, pready,
   input wire logic pad_out, pad_oe, pad_pull_up, pad_pull_down, input_side_clock,
   input wire logic output_side_clock, shared_clock_enable, global_set_reset, fabric_in_data,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // config shadow
   logic [7:0] cfg_r;
   logic [7:0] cfg_nxt;
   assign cfg_nxt = (psel && penable && pready && pwrite && paddr == 12'h000) ? pwdata[7:0] : cfg_r;
   always_ff @(posedge sys_clk) cfg_r <= reset ? 8'h00 : cfg_nxt;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   AST_GSR_IN: assert property (global_set_reset [*3] |-> fabric_in_data == cfg_r[0])
      else $error("input ff not at init");
   AST_GSR_OUT: assert property (global_set_reset [*3] |-> pad_out == cfg_r[1])
      else $error("output ff not at init");
   AST_PULL: assert property ($stable(cfg_r) [*2] |-> pad_pull_up == (cfg_r[7:6] == 2'b00)
      && pad_pull_down == (cfg_r[7:6] == 2'b01)) else $error("pull state wrong");
   AST_DRIVE: assert property ($stable(cfg_r) [*2] |-> pad_oe == (cfg_r[7:6] == 2'b10))
      else $error("pad drive wrong");
   AST_HOLD_IN: assert property ((cfg_r[4] && !shared_clock_enable && !global_set_reset
      && $stable(cfg_r)) [*4] |-> $stable(fabric_in_data)) else $error("input ff moved");
   AST_HOLD_OUT: assert property ((cfg_r[5] && !shared_clock_enable && !global_set_reset
      && $stable(cfg_r)) [*4] |-> $stable(pad_out)) else $error("output ff moved");
   AST_STILL_IN: assert property ((!global_set_reset && $stable(input_side_clock)
      && $stable(cfg_r)) [*8] |-> $stable(fabric_in_data)) else $error("input ff moved");
   AST_STILL_OUT: assert property ((!global_set_reset && $stable(output_side_clock)
      && $stable(cfg_r)) [*8] |-> $stable(pad_out)) else $error("output ff moved");
endmodule

// ==== bench/testbench.sv ====
/* self-checking bench for pad_cell with an apb master.
   assumes pad_model and pad_cell_asserts are compiled first */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, e;
   logic input_side_clock = 0, output_side_clock = 0, shared_clock_enable = 1;
   logic global_set_reset = 0, fabric_out_data = 0, ext_en = 0, ext_val = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down, fabric_in_data;
   int n_fail = 0, n_compared = 0;
   pad_cell u_pad_cell (.sys_clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .pad_in, .pad_out, .pad_oe, .pad_pull_up, .pad_pull_down,
      .input_side_clock, .output_side_clock, .shared_clock_enable, .global_set_reset,
      .fabric_out_data, .fabric_in_data);
   pad_model u_pad_model (.sys_clk, .pad_out, .pad_oe, .pad_pull_up, .pad_pull_down, .ext_en,
      .ext_val, .pad_in);
   initial forever #2.5 sys_clk = ~sys_clk;
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      print_verdict();
   end
   // ==========
   // shared tasks
   task chk(input string n, input logic [31:0] x, input logic [31:0] y);
      n_compared++;
      if (y !== x) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", n, x, y);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // pad must settle before the cell clock moves
   task edge_to(input logic side, input logic lvl);
      repeat (4) @(posedge sys_clk);
      if (side) output_side_clock <= lvl;
      else input_side_clock <= lvl;
      repeat (8) @(posedge sys_clk);
   endtask
   task print_verdict;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ==========
   // scenarios
   task s_regs;
      apb(0, 12'h000, 0);
      chk("cfg", 0, q);
      chk("pull up", 1, pad_pull_up);
      apb(0, 12'h008, 0);
      chk("unmapped", 1, e);
   endtask
   task s_in;
      ext_en <= 1;
      ext_val <= 1;
      apb(1, 12'h000, 32'hc0);
      edge_to(0, 1);
      chk("in rise", 1, fabric_in_data);
      apb(1, 12'h000, 32'hf4);
      ext_val <= 0;
      edge_to(0, 0);
      chk("in fall", 0, fabric_in_data);
      shared_clock_enable <= 0;
      ext_val <= 1;
      fabric_out_data <= 1;
      edge_to(0, 1);
      edge_to(0, 0);
      edge_to(1, 1);
      chk("in hold", 0, fabric_in_data);
      chk("out hold", 0, pad_out);
      shared_clock_enable <= 1;
      edge_to(0, 1);
      edge_to(0, 0);
      chk("in enabled", 1, fabric_in_data);
   endtask
   task s_out;
      shared_clock_enable <= 0;
      ext_en <= 0;
      apb(1, 12'h000, 32'h90);
      edge_to(1, 0);
      edge_to(1, 1);
      chk("out free", 1, pad_out);
      chk("drive", 1, pad_oe);
      apb(0, 12'h004, 0);
      chk("status", 32'h7, q);
      apb(1, 12'h000, 32'h50);
      repeat (8) @(posedge sys_clk);
      apb(0, 12'h004, 0);
      chk("pulled low", 32'h3, q);
      shared_clock_enable <= 1;
   endtask
   task s_gsr;
      for (int i = 1; i < 3; i++) begin
         apb(1, 12'h000, i);
         global_set_reset <= 1;
         repeat (4) @(posedge sys_clk);
         global_set_reset <= 0;
         @(posedge sys_clk);
         chk("gsr in", i[0], fabric_in_data);
         chk("gsr out", i[1], pad_out);
      end
   endtask
   initial begin
      repeat (6) @(posedge sys_clk);
      reset <= 0;
      s_regs();
      s_in();
      s_out();
      s_gsr();
      print_verdict();
   end
endmodule
bind pad_cell pad_cell_asserts u_pad_cell_asserts (.sys_clk, .reset, .psel, .penable, .pwrite,
   .pready, .pad_out, .pad_oe, .pad_pull_up, .pad_pull_down, .input_side_clock,
   .output_side_clock, .shared_clock_enable, .global_set_reset, .fabric_in_data, .paddr, .pwdata);
